// file: design/rps_params.svh
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH
// Register indices; byte address is four times the index
`define RPS_IDX_CTRL 8'h00
`define RPS_IDX_STRENGTH 8'h0f
`define RPS_IDX_PROTO 8'h01
`define RPS_IDX_RXSPEC 8'h0a
`define RPS_IDX_PMSTAT 8'h10
// Register byte addresses
`define RPS_ADDR_CTRL 12'h000
`define RPS_ADDR_STRENGTH 12'h03c
`define RPS_ADDR_PROTO 12'h004
`define RPS_ADDR_RXSPEC 12'h028
`define RPS_ADDR_PMSTAT 12'h040
// Control register fields
`define RPS_CTRL_STBY 7
`define RPS_CTRL_RFON 5
`define RPS_CTRL_TXPWR 4
`define RPS_CTRL_SWAP 3
`define RPS_CTRL_RXON 1
`define RPS_CTRL_RESET 8'h00
// Strength register fields
`define RPS_STR_OSC 6
// Receiver filter preset applied on protocol write
`define RPS_RXSPEC_PRESET 8'h40
// Timing in ns and cycles at 50 ns period
`define RPS_CLK_NS 50
`define RPS_CONFIRM_NS 100000
`define RPS_CONFIRM_CYC (`RPS_CONFIRM_NS / `RPS_CLK_NS)
`define RPS_STBY_REC_NS 100000
`define RPS_STBY_REC_CYC (`RPS_STBY_REC_NS / `RPS_CLK_NS)
`define RPS_IDLE_REC_NS 25000
`define RPS_IDLE_REC_CYC (`RPS_IDLE_REC_NS / `RPS_CLK_NS)
`define RPS_SETTLE_CYC 64
`endif

// file: design/rps_pkg.sv
package rps_pkg;
  typedef enum logic [2:0] {
    RPS_OFF = 3'b000,
    RPS_AUX = 3'b001,
    RPS_START = 3'b010,
    RPS_CONFIRM = 3'b011,
    RPS_ACTIVE = 3'b100
  } rps_state_t;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic tx_half;
    logic reg_on;
    logic reg_lowpwr;
    logic osc_on;
    logic aux_supply;
  } rps_power_t;

  typedef struct packed {
    rps_state_t st;
    logic [7:0] ctrl;
    logic [7:0] proto;
    logic [7:0] rxspec;
    logic [2:0] main_str;
    logic [2:0] aux_str;
    logic [15:0] settle_cnt;
    logic [15:0] tmr;
    logic [15:0] rec_cnt;
    logic aux_en_d;
    logic clk_hf;
    logic ready;
    logic [31:0] prdata;
  } rps_regs_t;
endpackage

// file: design/rps_top.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "rps_params.svh"
// Contract
// - Seven power states from main enable, aux enable and three control bits.
// - Main enable high turns on regulators, oscillator and system clock.
// - Aux enable alone keeps aux supply and 60 kHz clock out.
// - Aux enable rising edge from full off starts supplies like main enable.
// - Without main enable within 100 us after clock switch, return to off.
// - Both enables low: everything off, no supply, no clock; in start and confirm the code keeps them on until the confirm timeout.
// - Standby bit: regulators low power, oscillator and clock on, RF ignored.
// - Standby, RF-on and receive-only clear: RX and TX off.
// - Receive-only set with RF-on clear: receiver only.
// - RF-on set: RX and TX on; power-select one gives half power.
// - After settle, clock switches from 60 kHz to crystal clock; ready.
// - Standby to full operation within 100 us.
// - RF-disabled active mode to full operation within 25 us.
// - Swap bit zero: input one to main receiver; one swaps routing.
// - On tag response, both strengths are stored in strength register.
// - Peak strength is held until read after the packet.
// - Strengths clear at the start of each reader transmission.
// - Strength codes are three bits, levels one to seven.
// - Strength register: b6 oscillator stable, b5:3 aux, b2:0 main.
// - Protocol write loads filter presets; later special writes override.
// - Transmit power-select is bit 4 of the control register.
module rps_top #(
  parameter int unsigned SETTLE_CYC = `RPS_SETTLE_CYC,
  parameter int unsigned CONFIRM_CYC = `RPS_CONFIRM_CYC
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic main_enable_pin, // Main enable
  input wire logic aux_enable_pin, // Auxiliary enable
  input wire logic osc_stable, // Crystal oscillator stable
  input wire logic supplies_settled, // Regulators settled
  input wire logic tx_start, // Reader transmission start pulse
  input wire logic rx_active, // Tag response in progress
  input wire logic [2:0] rssi_in_one, // Level on receive input one
  input wire logic [2:0] rssi_in_two, // Level on receive input two
  output rps_pkg::rps_power_t power, // Section enables
  output logic sysclk_hf_sel, // 1 crystal clock, 0 60 kHz clock
  output logic sysclk_en, // System clock output running
  output logic main_rx_sel_two, // Main receiver takes input two
  output logic full_op_ready, // Ready for full operation
  output logic [7:0] rx_filter_cfg // Active receiver filter setting
);
  rps_pkg::rps_regs_t r, n;
  logic wr, rd, addr_ok, aux_rise, ctrl_wr;
  logic [2:0] main_lvl, aux_lvl;
  rps_pkg::rps_power_t pw;

  // Bus decode, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign addr_ok = paddr == `RPS_ADDR_CTRL || paddr == `RPS_ADDR_STRENGTH || paddr == `RPS_ADDR_PROTO ||
                   paddr == `RPS_ADDR_RXSPEC || paddr == `RPS_ADDR_PMSTAT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = r.prdata;
  assign aux_rise = aux_enable_pin && !r.aux_en_d;
  assign ctrl_wr = wr && paddr == `RPS_ADDR_CTRL;

  // Input routing by swap bit
  assign main_lvl = r.ctrl[`RPS_CTRL_SWAP] ? rssi_in_two : rssi_in_one;
  assign aux_lvl = r.ctrl[`RPS_CTRL_SWAP] ? rssi_in_one : rssi_in_two;
  assign main_rx_sel_two = r.ctrl[`RPS_CTRL_SWAP];

  // Power decode per state and control bits
  always_comb begin
    pw = '0;
    case (r.st)
      rps_pkg::RPS_AUX: begin
        pw.aux_supply = 1'b1;
      end
      rps_pkg::RPS_START, rps_pkg::RPS_CONFIRM: begin
        pw.aux_supply = 1'b1;
        pw.reg_on = 1'b1;
        pw.osc_on = 1'b1;
      end
      rps_pkg::RPS_ACTIVE: begin
        pw.aux_supply = 1'b1;
        pw.reg_on = 1'b1;
        pw.osc_on = 1'b1;
        if (r.ctrl[`RPS_CTRL_STBY]) begin
          pw.reg_lowpwr = 1'b1;
        end else if (r.ctrl[`RPS_CTRL_RFON]) begin
          pw.rx_on = 1'b1;
          pw.tx_on = 1'b1;
          pw.tx_half = r.ctrl[`RPS_CTRL_TXPWR];
        end else begin
          pw.rx_on = r.ctrl[`RPS_CTRL_RXON];
        end
      end
      default: pw = '0;
    endcase
  end

  // Next-state logic
  always_comb begin
    n = r;
    n.aux_en_d = aux_enable_pin;
    n.prdata = '0;
    // Power sequencing
    case (r.st)
      rps_pkg::RPS_OFF: begin
        if (main_enable_pin || aux_rise) begin
          n.st = rps_pkg::RPS_START;
          n.settle_cnt = '0;
        end else if (aux_enable_pin) begin
          n.st = rps_pkg::RPS_AUX;
        end
      end
      rps_pkg::RPS_AUX: begin
        if (main_enable_pin) begin
          n.st = rps_pkg::RPS_START;
          n.settle_cnt = '0;
        end else if (!aux_enable_pin) begin
          n.st = rps_pkg::RPS_OFF;
        end
      end
      rps_pkg::RPS_START: begin
        if (osc_stable && supplies_settled && r.settle_cnt >= 16'(SETTLE_CYC - 1)) begin
          n.clk_hf = 1'b1;
          n.tmr = '0;
          n.st = main_enable_pin ? rps_pkg::RPS_ACTIVE : rps_pkg::RPS_CONFIRM;
          n.ready = main_enable_pin;
        end else begin
          n.settle_cnt = r.settle_cnt + 16'h0001;
        end
      end
      rps_pkg::RPS_CONFIRM: begin
        if (main_enable_pin) begin
          n.st = rps_pkg::RPS_ACTIVE;
          n.ready = 1'b1;
        end else if (r.tmr >= 16'(CONFIRM_CYC - 1)) begin
          n.st = rps_pkg::RPS_OFF;
          n.clk_hf = 1'b0;
        end else begin
          n.tmr = r.tmr + 16'h0001;
        end
      end
      rps_pkg::RPS_ACTIVE: begin
        if (!main_enable_pin) begin
          n.st = aux_enable_pin ? rps_pkg::RPS_AUX : rps_pkg::RPS_OFF;
          n.clk_hf = 1'b0;
          n.ready = 1'b0;
        end
      end
      default: n.st = rps_pkg::RPS_OFF;
    endcase
    // Recovery to full operation; abandoned once the block leaves active
    if (r.st != rps_pkg::RPS_ACTIVE || !main_enable_pin) begin
      n.rec_cnt = '0;
    end else if (r.rec_cnt != '0) begin
      n.rec_cnt = r.rec_cnt - 16'h0001;
      if (r.rec_cnt == 16'h0001) begin
        n.ready = 1'b1;
      end
    end
    if (ctrl_wr && r.st == rps_pkg::RPS_ACTIVE && pwdata[`RPS_CTRL_RFON]) begin
      if (r.ctrl[`RPS_CTRL_STBY] && !pwdata[`RPS_CTRL_STBY]) begin
        n.rec_cnt = 16'(`RPS_STBY_REC_CYC);
        n.ready = 1'b0;
      end else if (!r.ctrl[`RPS_CTRL_STBY] && !r.ctrl[`RPS_CTRL_RFON] && !r.ctrl[`RPS_CTRL_RXON]) begin
        n.rec_cnt = 16'(`RPS_IDLE_REC_CYC);
        n.ready = 1'b0;
      end
    end
    // Register writes
    if (ctrl_wr) begin
      n.ctrl = pwdata[7:0];
    end
    if (wr && paddr == `RPS_ADDR_PROTO) begin
      n.proto = pwdata[7:0];
      n.rxspec = `RPS_RXSPEC_PRESET;
    end
    if (wr && paddr == `RPS_ADDR_RXSPEC) begin
      n.rxspec = pwdata[7:0];
    end
    // Peak-held strengths, cleared by transmission
    if (tx_start) begin
      n.main_str = '0;
      n.aux_str = '0;
    end else if (rx_active) begin
      if (main_lvl > r.main_str) n.main_str = main_lvl;
      if (aux_lvl > r.aux_str) n.aux_str = aux_lvl;
    end
    // Read data captured in setup phase
    if (rd) begin
      case (paddr)
        `RPS_ADDR_CTRL: n.prdata = {24'h000000, r.ctrl};
        `RPS_ADDR_STRENGTH: n.prdata = {24'h000000, 1'b0, osc_stable, r.aux_str, r.main_str};
        `RPS_ADDR_PROTO: n.prdata = {24'h000000, r.proto};
        `RPS_ADDR_RXSPEC: n.prdata = {24'h000000, r.rxspec};
        `RPS_ADDR_PMSTAT: n.prdata = {26'h0000000, r.ready, r.clk_hf, 1'b0, r.st};
        default: n.prdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign power = pw;
  assign sysclk_hf_sel = r.clk_hf;
  assign sysclk_en = r.st != rps_pkg::RPS_OFF;
  assign full_op_ready = r.ready;
  assign rx_filter_cfg = r.rxspec;

  // Timeout returns to off after the confirm window
  a_confirm_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_CONFIRM && !main_enable_pin && r.tmr == 16'(CONFIRM_CYC - 1))
      |=> r.st == rps_pkg::RPS_OFF)
    else $error("confirm timeout missed");
  a_off_dark: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == rps_pkg::RPS_OFF |-> !sysclk_en && power == '0)
    else $error("off state not dark");
  a_tx_half_pwr: assert property (@(posedge pclk) disable iff (!presetn)
    power.tx_on |-> power.tx_half == r.ctrl[`RPS_CTRL_TXPWR] && power.rx_on)
    else $error("tx power select wrong");
  a_stby_no_rf: assert property (@(posedge pclk) disable iff (!presetn)
    power.reg_lowpwr |-> !power.tx_on && !power.rx_on && power.osc_on)
    else $error("standby leaks rf");
  a_swap_route: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_active && !tx_start && !r.ctrl[`RPS_CTRL_SWAP]) |=> r.main_str >= $past(rssi_in_one) && r.aux_str >= $past(rssi_in_two))
    else $error("swap routing wrong");
  a_str_clear: assert property (@(posedge pclk) disable iff (!presetn)
    tx_start |=> r.main_str == 3'h0 && r.aux_str == 3'h0)
    else $error("strength not cleared");
  a_peak_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_start |=> r.main_str >= $past(r.main_str))
    else $error("peak not held");
  a_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `RPS_ADDR_PROTO) |=> rx_filter_cfg == `RPS_RXSPEC_PRESET)
    else $error("preset not loaded");
  a_aux_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_OFF && aux_rise) |=> r.st == rps_pkg::RPS_START ##0 power.osc_on)
    else $error("aux wake failed");

  // Control byte lands as written
  a_ctrl_load: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr |=> r.ctrl == $past(pwdata[7:0]))
    else $error("control write lost");

  // Main enable starts the supplies from off
  a_main_start: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_OFF && main_enable_pin) |=> r.st == rps_pkg::RPS_START)
    else $error("main enable ignored");

  // Active keeps regulators, oscillator and crystal clock on
  a_active_on: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == rps_pkg::RPS_ACTIVE |-> power.reg_on && power.osc_on && sysclk_hf_sel && sysclk_en)
    else $error("active not powered");

  // Partial power down gives aux supply and slow clock only
  a_aux_only: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == rps_pkg::RPS_AUX |-> power.aux_supply && !power.osc_on && !power.reg_on && sysclk_en && !sysclk_hf_sel)
    else $error("aux mode wrong");

  // Wake-up runs supplies and oscillator on the slow clock
  a_wake_supply: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == rps_pkg::RPS_START |-> power.reg_on && power.osc_on && !sysclk_hf_sel)
    else $error("start not powered");

  // Confirmation by main enable keeps the block active
  a_confirm_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_CONFIRM && main_enable_pin) |=> r.st == rps_pkg::RPS_ACTIVE && full_op_ready)
    else $error("confirm not kept");

  // Off runs no crystal clock and is never ready
  a_off_slow_clock: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == rps_pkg::RPS_OFF |-> !sysclk_hf_sel && !full_op_ready)
    else $error("off still clocked");

  // Both enables low drop an active block to off
  a_both_low: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && !main_enable_pin && !aux_enable_pin) |=> r.st == rps_pkg::RPS_OFF)
    else $error("both low not off");

  // Standby keeps regulators in low power with clock out
  a_stby_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && r.ctrl[`RPS_CTRL_STBY]) |-> power.reg_lowpwr && power.reg_on && sysclk_en)
    else $error("standby mode wrong");

  // Idle active mode keeps RF sections off
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && r.ctrl[7:5] == 3'h0 && !r.ctrl[`RPS_CTRL_RXON])
      |-> !power.rx_on && !power.tx_on && !power.reg_lowpwr && power.osc_on)
    else $error("idle mode not quiet");

  // Receive-only mode turns the receiver alone on
  a_rx_only: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && !r.ctrl[`RPS_CTRL_STBY] && !r.ctrl[`RPS_CTRL_RFON] && r.ctrl[`RPS_CTRL_RXON])
      |-> power.rx_on && !power.tx_on)
    else $error("receive only wrong");

  // RF-on runs both receiver and transmitter
  a_rf_full: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && !r.ctrl[`RPS_CTRL_STBY] && r.ctrl[`RPS_CTRL_RFON]) |-> power.rx_on && power.tx_on)
    else $error("rf section off");

  // Leaving start selects the crystal clock
  a_hf_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_START && n.st != rps_pkg::RPS_START) |=> sysclk_hf_sel)
    else $error("clock not switched");

  // Ready only while active
  a_ready_active: assert property (@(posedge pclk) disable iff (!presetn)
    full_op_ready |-> r.st == rps_pkg::RPS_ACTIVE)
    else $error("ready outside active");

  // Leaving standby for RF-on starts the long recovery
  a_stby_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && r.st == rps_pkg::RPS_ACTIVE && main_enable_pin && pwdata[`RPS_CTRL_RFON] &&
      r.ctrl[`RPS_CTRL_STBY] && !pwdata[`RPS_CTRL_STBY]) |=> !full_op_ready && r.rec_cnt == 16'(`RPS_STBY_REC_CYC))
    else $error("standby recovery wrong");

  // Recovery never exceeds the standby bound
  a_rec_bound: assert property (@(posedge pclk) disable iff (!presetn)
    r.rec_cnt <= 16'(`RPS_STBY_REC_CYC))
    else $error("recovery too long");

  // Leaving idle for RF-on starts the short recovery
  a_idle_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && r.st == rps_pkg::RPS_ACTIVE && main_enable_pin && pwdata[`RPS_CTRL_RFON] && !r.ctrl[`RPS_CTRL_STBY] &&
      !r.ctrl[`RPS_CTRL_RFON] && !r.ctrl[`RPS_CTRL_RXON]) |=> !full_op_ready && r.rec_cnt == 16'(`RPS_IDLE_REC_CYC))
    else $error("idle recovery wrong");

  // Last recovery count restores ready
  a_rec_done: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_ACTIVE && main_enable_pin && r.rec_cnt == 16'h0001 && !ctrl_wr) |=> full_op_ready)
    else $error("recovery never ends");

  // Aux peak never falls without a transmission
  a_aux_peak: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_start |=> r.aux_str >= $past(r.aux_str))
    else $error("aux peak not held");

  // Both routed levels are taken during a response
  a_peak_take: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_active && !tx_start) |=> r.main_str >= $past(main_lvl) && r.aux_str >= $past(aux_lvl))
    else $error("level not stored");

  // A nonzero level leaves a nonzero code
  a_level_code: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_active && !tx_start && main_lvl != 3'h0) |=> r.main_str != 3'h0)
    else $error("level code lost");

  // Strength word layout on read
  a_strength_word: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == `RPS_ADDR_STRENGTH) |=> prdata == {24'h000000, 1'b0, $past(osc_stable), $past(r.aux_str), $past(r.main_str)})
    else $error("strength word wrong");

  // Special write overrides the preset
  a_filter_override: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `RPS_ADDR_RXSPEC) |=> rx_filter_cfg == $past(pwdata[7:0]))
    else $error("filter not overridden");

  // Confirm timer steps once per bus clock
  a_confirm_count: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rps_pkg::RPS_CONFIRM && !main_enable_pin && r.tmr < 16'(CONFIRM_CYC - 1)) |=> r.tmr == $past(r.tmr) + 16'h0001)
    else $error("confirm timer stalled");

  // Read data returns to zero outside reads
  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !rd |=> prdata == 32'h00000000)
    else $error("read data not cleared");
endmodule

// file: verification/rps_analog_model.sv
`timescale 1ns/1ps
// Analog front end: oscillator and regulators settle some cycles after enable
module rps_analog_model #(
  parameter int unsigned DLY = 6
) (
  input wire logic clk, // Bus clock
  input wire logic rst_n, // Async reset, low
  input rps_pkg::rps_power_t power, // Section enables from the block
  output logic osc_stable, // Oscillator stable
  output logic supplies_settled // Regulators settled
);
  int unsigned cnt;
  // Settle counter restarts whenever the oscillator is switched off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (!power.osc_on) begin
      cnt <= 0;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end
  end
  // Status lines fall back low once the sections are off
  assign osc_stable = power.osc_on && (cnt >= DLY);
  assign supplies_settled = power.reg_on && (cnt >= DLY - 2);
endmodule

// file: verification/test_reader_power_mode_and_strength_status.sv
`timescale 1ns/1ps
`include "rps_params.svh"
module test_reader_power_mode_and_strength_status;
  localparam int unsigned CONF = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, seed = 32'hd74e;
  logic pready, pslverr, serr, hf, en, swp, rdy, osc, sup;
  logic main_en = 0, aux_en = 0, tx_start = 0, rx_act = 0;
  logic [2:0] l1 = 0, l2 = 0, m1, m2, v1, v2;
  logic [7:0] filt, c;
  logic [3:0] e;
  rps_pkg::rps_power_t pw;
  int miscompares = 0, n_checks = 0, cyc = 0, i, k;
  always #25 pclk = ~pclk;
  rps_top #(.SETTLE_CYC(4), .CONFIRM_CYC(CONF)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_enable_pin(main_en), .aux_enable_pin(aux_en), .osc_stable(osc),
    .supplies_settled(sup), .tx_start(tx_start), .rx_active(rx_act), .rssi_in_one(l1), .rssi_in_two(l2),
    .power(pw), .sysclk_hf_sel(hf), .sysclk_en(en), .main_rx_sel_two(swp), .full_op_ready(rdy),
    .rx_filter_cfg(filt));
  rps_analog_model model (.clk(pclk), .rst_n(presetn), .power(pw), .osc_stable(osc), .supplies_settled(sup));
  // Xorshift source with fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected {rx, tx, half, lowpwr} for a control byte
  function automatic logic [3:0] exp_pwr(input logic [7:0] v);
    return {~v[7] & (v[5] | v[1]), ~v[7] & v[5], ~v[7] & v[5] & v[4], v[7]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wait_hf();
    for (k = 0; k < 300 && hf !== 1'b1; k++) @(posedge pclk);
  endtask
  // Clear, capture peaks during a tag response, then read them back
  task automatic rssi_run(input logic s);
    @(posedge pclk) tx_start <= 1;
    @(posedge pclk) tx_start <= 0;
    apb(0, `RPS_ADDR_STRENGTH, 0);
    chk(q, 32'h40);
    m1 = 0; m2 = 0;
    for (i = 0; i < 6; i++) begin
      v1 = 3'(rnd()); v2 = 3'(rnd());
      @(posedge pclk);
      rx_act <= 1; l1 <= v1; l2 <= v2;
      if ((s ? v2 : v1) > m1) m1 = s ? v2 : v1;
      if ((s ? v1 : v2) > m2) m2 = s ? v1 : v2;
    end
    @(posedge pclk) rx_act <= 0;
    l1 <= 3'h7; l2 <= 3'h7;
    apb(0, `RPS_ADDR_STRENGTH, 0);
    chk(q, {24'h0, 2'b01, m2, m1});
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({pw, en, hf}, 0);
    apb(0, `RPS_ADDR_CTRL, 0);
    chk(q, 0);
    // Aux wake without confirmation falls back to aux-only mode
    @(posedge pclk) aux_en <= 1;
    wait_hf();
    chk({hf, en, pw.osc_on}, 3'h7);
    repeat (CONF + 3) @(posedge pclk);
    chk({hf, pw.osc_on}, 0);
    chk({pw.aux_supply, en}, 2'b11);
    aux_en <= 0;
    repeat (2) @(posedge pclk);
    aux_en <= 1;
    wait_hf();
    main_en <= 1;
    repeat (CONF + 3) @(posedge pclk);
    chk({hf, en, pw.osc_on, pw.reg_on}, 4'hf);
    aux_en <= 0;
    // Mode writes only once the crystal clock is out
    for (int j = 0; j < 14; j++) begin
      c = (j < 5) ? (j == 0 ? 8'hba : j == 1 ? 8'h02 : j == 2 ? 8'h30 : j == 3 ? 8'h20 : 8'h00) : rnd();
      apb(1, `RPS_ADDR_CTRL, {24'h0, c});
      @(posedge pclk);
      e = exp_pwr(c);
      chk({pw.rx_on, pw.tx_on, pw.tx_half, pw.reg_lowpwr}, e);
      apb(0, `RPS_ADDR_CTRL, 0);
      chk(q, {24'h0, c});
      chk(swp, c[3]);
    end
    apb(1, `RPS_ADDR_CTRL, 32'h20);
    rssi_run(0);
    apb(1, `RPS_ADDR_CTRL, 32'h28);
    rssi_run(1);
    // Protocol write presets the filter, a later special write overrides
    apb(1, `RPS_ADDR_PROTO, 32'h11);
    @(posedge pclk);
    chk(filt, `RPS_RXSPEC_PRESET);
    apb(1, `RPS_ADDR_RXSPEC, 32'h5a);
    @(posedge pclk);
    chk(filt, 8'h5a);
    apb(0, 12'h100, 0);
    chk({serr, q[7:0]}, 9'h100);
    // Recovery from standby and from RF-off idle
    for (int j = 0; j < 2; j++) begin
      apb(1, `RPS_ADDR_CTRL, j ? 32'h00 : 32'h80);
      for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge pclk);
      apb(1, `RPS_ADDR_CTRL, 32'h20);
      @(posedge pclk);
      chk(rdy, 0);
      for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge pclk);
      chk(k <= (j ? 500 : 2000), 1);
    end
    stop_test();
  end
endmodule
